// >>> link_model.sv
// behavioural link layer seen from the transport transmit sequencer.
// assumes one clock shared with the sequencer; drives on the falling edge.
`timescale 1ns/1ps
module link_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic valid_i,
   input wire logic done_i,
   input wire logic slow_i,
   input wire logic err_i,
   output logic ready_o,
   output logic status_valid_o,
   output logic status_err_o
);
   logic [1:0] wait_q;

   // ------------------------------------------------------------
   // word acceptance and ending status
   // ------------------------------------------------------------
   // slow mode stalls at random and delays the status
   always @(negedge clk_i) begin
      if (rst_i) begin
         ready_o <= 1'b0;
         status_valid_o <= 1'b0;
         status_err_o <= 1'b0;
         wait_q <= 2'h0;
      end else begin
         ready_o <= valid_i && (!slow_i || ($urandom_range(1) == 1));
         status_valid_o <= (wait_q == 2'h1);
         // outside the status pulse the error line toggles, never holds
         status_err_o <= (wait_q == 2'h1) ? err_i : ~status_err_o;
         if (done_i) begin
            wait_q <= slow_i ? 2'h3 : 2'h1;
         end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end
      end
   end
endmodule : link_model

// >>> tb_host_transport_ctrl_dmasetup_tx.sv
// self-checking bench for the transport transmit sequencer.
// assumes xport_tx_pkg and link_model are compiled first.
`timescale 1ns/1ps
module tb_host_transport_ctrl_dmasetup_tx;
   logic clk_i, rst_i, ctrl_wr_i, dma_req_i, tx_ready_i, link_illegal_i, link_rx_active_i;
   logic status_valid_i, status_err_i, tx_req_o, tx_valid_o, tx_done_o;
   logic ctrl_pending_o, dma_pending_o, status_chk_o, status_err_o, slow, link_err;
   logic [31:0] tx_data_o;
   logic [191:0] r;
   xport_tx_pkg::shadow_s shadow_i, sh;
   xport_tx_pkg::dma_setup_s dma_i, dm;
   xport_tx_pkg::xport_state_e state_o;
   logic [31:0] cap[$];
   int n_errors, total_checks, cyc;

   xport_tx xport_tx_inst (.clk_i(clk_i), .rst_i(rst_i), .ctrl_wr_i(ctrl_wr_i),
      .shadow_i(shadow_i), .dma_req_i(dma_req_i), .dma_i(dma_i), .tx_ready_i(tx_ready_i),
      .link_illegal_i(link_illegal_i), .link_rx_active_i(link_rx_active_i),
      .status_valid_i(status_valid_i), .status_err_i(status_err_i), .tx_req_o(tx_req_o),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_done_o(tx_done_o),
      .ctrl_pending_o(ctrl_pending_o), .dma_pending_o(dma_pending_o),
      .status_chk_o(status_chk_o), .status_err_o(status_err_o), .state_o(state_o));

   link_model link_model_inst (.clk_i(clk_i), .rst_i(rst_i), .valid_i(tx_valid_o),
      .done_i(tx_done_o), .slow_i(slow), .err_i(link_err), .ready_o(tx_ready_i),
      .status_valid_o(status_valid_i), .status_err_o(status_err_i));

   // ------------------------------------------------------------
   // clock, cycle limit and word capture
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // words taken by the link at edges with no abort
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end else if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i && !link_illegal_i &&
                   !link_rx_active_i) begin
         cap.push_back(tx_data_o);
      end
   end

   // ------------------------------------------------------------
   // expectations and checks
   // ------------------------------------------------------------
   function automatic logic [31:0] exp_word(input logic ctrl, input int i);
      logic [7:0] f;
      f = 8'h00;
      f[xport_tx_pkg::DIR_BIT_POS] = dm.dir;
      f[xport_tx_pkg::INTR_BIT_POS] = dm.intr;
      f[xport_tx_pkg::AUTO_BIT_POS] = dm.auto_act;
      if (ctrl) begin
         case (i)
            0: return {sh.features, sh.command, xport_tx_pkg::CTRL_FLAG_BYTE,
                       xport_tx_pkg::TYPE_REG_H2D};
            1: return {sh.device, sh.lba[23:0]};
            2: return {sh.features_exp, sh.lba[47:24]};
            3: return {sh.control, sh.icc, sh.count};
            default: return 32'h0000_0000;
         endcase
      end
      case (i)
         0: return {16'h0000, f, xport_tx_pkg::TYPE_DMA_SETUP};
         1: return dm.buf_id[31:0];
         2: return dm.buf_id[63:32];
         4: return dm.buf_off;
         5: return dm.xfer_cnt;
         default: return 32'h0000_0000;
      endcase
   endfunction : exp_word

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk

   // raise one request with fresh random contents, then scramble the inputs
   task automatic do_req(input logic ctrl, input logic dir);
      r = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
      sh = r[111:0];
      dm = r[130:0];
      dm.dir = dir;
      shadow_i = sh;
      dma_i = dm;
      ctrl_wr_i = ctrl;
      dma_req_i = !ctrl;
      cap.delete();
      @(negedge clk_i);
      ctrl_wr_i = 1'b0;
      dma_req_i = 1'b0;
      shadow_i = ~sh;
      dma_i = ~dm;
      chk(state_o === (ctrl ? xport_tx_pkg::ctrl_frame_build : xport_tx_pkg::dma_setup_build)
          && tx_req_o === 1'b1, "build not entered");
   endtask : do_req

   // follow one frame to its done pulse and ending status
   task automatic finish(input logic ctrl, input logic err);
      int n;
      n = 0;
      while (tx_done_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      chk(n < 200 && tx_valid_o === 1'b0 && state_o === (ctrl ?
          xport_tx_pkg::ctrl_frame_status_wait : xport_tx_pkg::dma_setup_status_wait),
          "no done into status wait");
      chk(cap.size() == (ctrl ? 5 : 7), "word count");
      foreach (cap[i]) chk(cap[i] === exp_word(ctrl, i), "frame word");
      link_err = err;
      n = 0;
      while (status_chk_o !== 1'b1 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      chk(n < 50 && state_o === xport_tx_pkg::transport_idle && status_err_o === err,
          "status outcome");
      chk((ctrl ? ctrl_pending_o : dma_pending_o) === err, "pending");
      cap.delete();
   endtask : finish

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {ctrl_wr_i, dma_req_i, link_illegal_i, link_rx_active_i, slow, link_err} = 6'h00;
      shadow_i = '0;
      dma_i = '0;
      rst_i = 1'b1;
      r = {160'h0, $urandom(32'hfffc)};
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      // clean frames, both link speeds, dma in both directions
      for (int k = 0; k < 6; k++) begin
         slow = k[0];
         do_req(k < 2, k[1]);
         finish(k < 2, 1'b0);
      end
      $display("clean frames done");
      // errored status keeps the frame and it is offered again
      for (int k = 0; k < 2; k++) begin
         slow = k[0];
         do_req(k[0], 1'b0);
         finish(k[0], 1'b1);
         finish(k[0], 1'b0);
      end
      $display("error retry done");
      // illegal transition and incoming frame abort each build
      slow = 1'b0;
      for (int k = 0; k < 4; k++) begin
         do_req(k[0], 1'b1);
         link_illegal_i = !k[1];
         link_rx_active_i = k[1];
         @(negedge clk_i);
         chk(state_o === xport_tx_pkg::transport_idle && tx_done_o === 1'b0 &&
             (k[0] ? ctrl_pending_o : dma_pending_o) === 1'b1, "abort");
         link_illegal_i = 1'b0;
         link_rx_active_i = 1'b0;
         finish(k[0], 1'b0);
      end
      $display("abort done");
      end_of_test();
   end
endmodule : tb_host_transport_ctrl_dmasetup_tx

// >>> xport_tx.sv
// host transport transmit sequencer for the control register frame
// and the first-party dma setup frame.
// assumes the link layer, the shadow registers and the application
// layer all run on clk_i; no input needs synchronising.
//
// Contract
// - shadow control write starts control build
// - control frame built, command flag cleared
// - last control word sent, done, status wait
// - illegal transition report abandons any build
// - incoming frame abandons any build
// - status waits take link ending status
// - clean control status returns idle, delivered
// - errored status returns idle, frame pending
// - application dma request starts dma build
// - dma frame carries direction, id, offset, count, flag
// - last dma word sent, done, status wait
// - clean dma status returns idle, not pending
// - dma indication from idle triggers dma build
`timescale 1ns/1ps
module xport_tx (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ctrl_wr_i,
   input wire xport_tx_pkg::shadow_s shadow_i,
   input wire logic dma_req_i,
   input wire xport_tx_pkg::dma_setup_s dma_i,
   input wire logic tx_ready_i,
   input wire logic link_illegal_i,
   input wire logic link_rx_active_i,
   input wire logic status_valid_i,
   input wire logic status_err_i,
   output logic tx_req_o,
   output logic tx_valid_o,
   output logic [31:0] tx_data_o,
   output logic tx_done_o,
   output logic ctrl_pending_o,
   output logic dma_pending_o,
   output logic status_chk_o,
   output logic status_err_o,
   output xport_tx_pkg::xport_state_e state_o
);

   // ----------------------------------------------------------------
   // state and storage
   // ----------------------------------------------------------------
   xport_tx_pkg::xport_state_e state_q, state_d;
   xport_tx_pkg::shadow_s shadow_q;
   xport_tx_pkg::dma_setup_s dma_q;
   logic [xport_tx_pkg::IDX_W-1:0] idx_q, idx_d;
   logic [31:0] data_d;
   logic valid_d, req_d, done_d;
   logic ctrl_pend_q, ctrl_pend_d, dma_pend_q, dma_pend_d;
   logic chk_q, err_q;

   // ----------------------------------------------------------------
   // frame words
   // ----------------------------------------------------------------
   logic [31:0] ctrl_w [0:4];
   logic [31:0] dma_w [0:6];
   logic [7:0] dma_flags;

   // a request taken this cycle already shapes the first word, since the
   // held copy only updates on the same edge that launches that word
   wire xport_tx_pkg::shadow_s shadow_src = ctrl_wr_i ? shadow_i : shadow_q;
   wire xport_tx_pkg::dma_setup_s dma_src = dma_req_i ? dma_i : dma_q;

   // register frame from the shadow copy, command flag clear
   assign ctrl_w[0] = {shadow_src.features, shadow_src.command,
                       xport_tx_pkg::CTRL_FLAG_BYTE,
                       xport_tx_pkg::TYPE_REG_H2D};
   assign ctrl_w[1] = {shadow_src.device, shadow_src.lba[23:0]};
   assign ctrl_w[2] = {shadow_src.features_exp, shadow_src.lba[47:24]};
   assign ctrl_w[3] = {shadow_src.control, shadow_src.icc, shadow_src.count};
   assign ctrl_w[4] = xport_tx_pkg::RSVD_WORD;

   // dma setup frame from the application copy
   always_comb begin
      dma_flags = 8'h00;
      dma_flags[xport_tx_pkg::DIR_BIT_POS] = dma_src.dir;
      dma_flags[xport_tx_pkg::INTR_BIT_POS] = dma_src.intr;
      dma_flags[xport_tx_pkg::AUTO_BIT_POS] = dma_src.auto_act;
   end
   assign dma_w[0] = {16'h0000, dma_flags, xport_tx_pkg::TYPE_DMA_SETUP};
   assign dma_w[1] = dma_src.buf_id[31:0];
   assign dma_w[2] = dma_src.buf_id[63:32];
   assign dma_w[3] = xport_tx_pkg::RSVD_WORD;
   assign dma_w[4] = dma_src.buf_off;
   assign dma_w[5] = dma_src.xfer_cnt;
   assign dma_w[6] = xport_tx_pkg::RSVD_WORD;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire in_build = (state_q == xport_tx_pkg::ctrl_frame_build) ||
                   (state_q == xport_tx_pkg::dma_setup_build);
   wire in_wait = (state_q == xport_tx_pkg::ctrl_frame_status_wait) ||
                  (state_q == xport_tx_pkg::dma_setup_status_wait);
   wire abort = in_build && (link_illegal_i || link_rx_active_i);
   wire accept = in_build && tx_valid_o && tx_ready_i && !abort;
   wire last_idx = (state_q == xport_tx_pkg::ctrl_frame_build) ?
                   (idx_q == xport_tx_pkg::CTRL_LAST_IDX) :
                   (idx_q == xport_tx_pkg::DMA_LAST_IDX);
   wire status_ok = in_wait && status_valid_i && !status_err_i;
   wire status_bad = in_wait && status_valid_i && status_err_i;
   wire start_ctrl = (state_q == xport_tx_pkg::transport_idle) &&
                     (ctrl_wr_i || ctrl_pend_q);
   wire start_dma = (state_q == xport_tx_pkg::transport_idle) &&
                    !start_ctrl && (dma_req_i || dma_pend_q);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      case (state_q)
         xport_tx_pkg::transport_idle: begin
            idx_d = xport_tx_pkg::IDX_RESET;
            if (start_ctrl) begin
               state_d = xport_tx_pkg::ctrl_frame_build;
            end else if (start_dma) begin
               state_d = xport_tx_pkg::dma_setup_build;
            end
         end
         xport_tx_pkg::ctrl_frame_build: begin
            if (abort) begin
               state_d = xport_tx_pkg::transport_idle;
            end else if (accept && last_idx) begin
               state_d = xport_tx_pkg::ctrl_frame_status_wait;
            end else if (accept) begin
               idx_d = idx_q + 3'h1;
            end
         end
         xport_tx_pkg::dma_setup_build: begin
            if (abort) begin
               state_d = xport_tx_pkg::transport_idle;
            end else if (accept && last_idx) begin
               state_d = xport_tx_pkg::dma_setup_status_wait;
            end else if (accept) begin
               idx_d = idx_q + 3'h1;
            end
         end
         xport_tx_pkg::ctrl_frame_status_wait,
         xport_tx_pkg::dma_setup_status_wait: begin
            if (status_valid_i) begin
               state_d = xport_tx_pkg::transport_idle;
            end
         end
         default: begin
            state_d = xport_tx_pkg::transport_idle;
         end
      endcase
   end

   // link-side outputs for the next cycle
   wire next_build = (state_d == xport_tx_pkg::ctrl_frame_build) ||
                     (state_d == xport_tx_pkg::dma_setup_build);
   assign valid_d = next_build;
   assign req_d = next_build;
   assign done_d = accept && last_idx;
   assign data_d = !next_build ? xport_tx_pkg::RSVD_WORD :
                   (state_d == xport_tx_pkg::ctrl_frame_build) ? ctrl_w[idx_d] :
                   dma_w[idx_d];

   // pending flags: a new request wins over a success clear
   assign ctrl_pend_d = ctrl_wr_i ? 1'b1 :
                        (status_ok && state_q == xport_tx_pkg::ctrl_frame_status_wait) ?
                        1'b0 : ctrl_pend_q;
   assign dma_pend_d = dma_req_i ? 1'b1 :
                       (status_ok && state_q == xport_tx_pkg::dma_setup_status_wait) ?
                       1'b0 : dma_pend_q;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // sequencer and link outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= xport_tx_pkg::transport_idle;
         idx_q <= xport_tx_pkg::IDX_RESET;
         tx_valid_o <= 1'b0;
         tx_req_o <= 1'b0;
         tx_done_o <= 1'b0;
         tx_data_o <= xport_tx_pkg::RSVD_WORD;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         tx_valid_o <= valid_d;
         tx_req_o <= req_d;
         tx_done_o <= done_d;
         tx_data_o <= data_d;
      end
   end

   // frame contents held until superseded by a new request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shadow_q <= '0;
         dma_q <= '0;
      end else begin
         if (ctrl_wr_i) begin
            shadow_q <= shadow_i;
         end
         if (dma_req_i) begin
            dma_q <= dma_i;
         end
      end
   end

   // pending marks and status outcome
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_pend_q <= 1'b0;
         dma_pend_q <= 1'b0;
         chk_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ctrl_pend_q <= ctrl_pend_d;
         dma_pend_q <= dma_pend_d;
         chk_q <= in_wait && status_valid_i;
         if (in_wait && status_valid_i) begin
            err_q <= status_bad;
         end
      end
   end

   assign ctrl_pending_o = ctrl_pend_q;
   assign dma_pending_o = dma_pend_q;
   assign status_chk_o = chk_q;
   assign status_err_o = err_q;
   assign state_o = state_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_idle_ctrl_wr;
      state_q == xport_tx_pkg::transport_idle && ctrl_wr_i;
   endsequence

   sequence s_enter_ctrl_build;
      state_q == xport_tx_pkg::ctrl_frame_build && tx_valid_o && tx_req_o;
   endsequence

   property p_ctrl_start;
      @(posedge clk_i) disable iff (rst_i)
         s_idle_ctrl_wr |=> s_enter_ctrl_build;
   endproperty
   a_ctrl_start: assert property (p_ctrl_start)
      else $error("control write did not start control build");

   property p_ctrl_flag;
      @(posedge clk_i) disable iff (rst_i)
         (state_q == xport_tx_pkg::ctrl_frame_build && idx_q == xport_tx_pkg::IDX_RESET
          && tx_valid_o) |-> (tx_data_o[15:8] == xport_tx_pkg::CTRL_FLAG_BYTE &&
          tx_data_o[7:0] == xport_tx_pkg::TYPE_REG_H2D);
   endproperty
   a_ctrl_flag: assert property (p_ctrl_flag)
      else $error("control frame first word wrong");

   property p_ctrl_done;
      @(posedge clk_i) disable iff (rst_i)
         (state_q == xport_tx_pkg::ctrl_frame_build && accept && last_idx) |=>
         (tx_done_o && state_q == xport_tx_pkg::ctrl_frame_status_wait && !tx_valid_o);
   endproperty
   a_ctrl_done: assert property (p_ctrl_done)
      else $error("control frame end not signalled");

   property p_abort_illegal;
      @(posedge clk_i) disable iff (rst_i)
         (in_build && link_illegal_i) |=>
         (state_q == xport_tx_pkg::transport_idle && !tx_done_o);
   endproperty
   a_abort_illegal: assert property (p_abort_illegal)
      else $error("illegal transition did not abandon build");

   property p_abort_rx;
      @(posedge clk_i) disable iff (rst_i)
         (in_build && link_rx_active_i) |=> state_q == xport_tx_pkg::transport_idle;
   endproperty
   a_abort_rx: assert property (p_abort_rx)
      else $error("incoming frame did not abandon build");

   property p_status_wait;
      @(posedge clk_i) disable iff (rst_i)
         (in_wait && !status_valid_i) |=> (state_q == $past(state_q));
   endproperty
   a_status_wait: assert property (p_status_wait)
      else $error("left status wait without ending status");

   property p_ctrl_ok;
      @(posedge clk_i) disable iff (rst_i)
         (state_q == xport_tx_pkg::ctrl_frame_status_wait && status_ok && !ctrl_wr_i)
         |=> (!ctrl_pending_o && status_chk_o && !status_err_o
              && state_q == xport_tx_pkg::transport_idle);
   endproperty
   a_ctrl_ok: assert property (p_ctrl_ok)
      else $error("clean control status not delivered");

   property p_err_pending;
      @(posedge clk_i) disable iff (rst_i)
         (status_bad && state_q == xport_tx_pkg::dma_setup_status_wait) |=>
         (dma_pending_o && status_err_o) ##1 (state_q != xport_tx_pkg::transport_idle);
   endproperty
   a_err_pending: assert property (p_err_pending)
      else $error("errored dma frame not kept pending");

   property p_dma_start;
      @(posedge clk_i) disable iff (rst_i)
         (state_q == xport_tx_pkg::transport_idle && dma_req_i && !ctrl_wr_i
          && !ctrl_pending_o) |=> state_q == xport_tx_pkg::dma_setup_build;
   endproperty
   a_dma_start: assert property (p_dma_start)
      else $error("dma request did not start dma build");

   property p_dma_ok;
      @(posedge clk_i) disable iff (rst_i)
         (state_q == xport_tx_pkg::dma_setup_status_wait && status_ok && !dma_req_i)
         |=> !dma_pending_o;
   endproperty
   a_dma_ok: assert property (p_dma_ok)
      else $error("clean dma status left frame pending");

endmodule : xport_tx

// >>> xport_tx_pkg.sv
// package for the host transport transmit sequencer: frame layouts,
// type codes, word counts and the carrier structs.
// assumes the link layer and the shadow/application logic share clk_i.
package xport_tx_pkg;

   // ----------------------------------------------------------------
   // frame type codes and flag fields
   // ----------------------------------------------------------------
   localparam logic [7:0] TYPE_REG_H2D = 8'h27;
   localparam logic [7:0] TYPE_DMA_SETUP = 8'h41;
   localparam logic [7:0] CTRL_FLAG_BYTE = 8'h00; // command flag cleared
   localparam int DIR_BIT_POS = 5;
   localparam int INTR_BIT_POS = 6;
   localparam int AUTO_BIT_POS = 7;
   localparam logic [31:0] RSVD_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // frame lengths in 32-bit words
   // ----------------------------------------------------------------
   localparam int IDX_W = 3;
   localparam logic [IDX_W-1:0] CTRL_LAST_IDX = 3'h4; // five words
   localparam logic [IDX_W-1:0] DMA_LAST_IDX = 3'h6; // seven words
   localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] command;
      logic [7:0] features;
      logic [7:0] features_exp;
      logic [47:0] lba;
      logic [7:0] device;
      logic [15:0] count;
      logic [7:0] icc;
      logic [7:0] control;
   } shadow_s;

   typedef struct packed {
      logic dir;      // 1: device to host
      logic intr;
      logic auto_act;
      logic [63:0] buf_id;
      logic [31:0] buf_off;
      logic [31:0] xfer_cnt;
   } dma_setup_s;

   typedef enum logic [2:0] {
      transport_idle,
      ctrl_frame_build,
      ctrl_frame_status_wait,
      dma_setup_build,
      dma_setup_status_wait
   } xport_state_e;

endpackage : xport_tx_pkg
